// ---- core/bcld_decoder.sv ----
// Purpose: decoder for bit, control, literal and table instructions
// Assumes: fetch unit and datapath run on pclk; flags and bank are current
// Notes:   two-word pairs yield one result, on the second word
// Behaviour
// - bit clear, set, toggle; pins, no flags
// - bit test skips take one, two, three cycles
// - conditional branch on eight flag tests
// - relative jump and call, eleven-bit offset
// - absolute call, low byte plus fast bit
// - absolute jump, low byte first word
// - 1111 words and zero word are nops
// - watchdog kick and standby update status bits
// - push and pop return stack top
// - interrupt return and subroutine return, fast restore
// - return loading constant, two cycles
// - add and subtract constant, arithmetic flags
// - and, or, xor constant; zero, negative
// - load and multiply constant, no flags
// - load bank number low nibble
// - two-word load of twelve-bit pointer
// - table read with four pointer modes
// - table write with four pointer modes
// - bit modify on timer clears prescaler
// - access bit picks access bank or bank
// - absolute targets are twenty bits wide
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ps
module bcld_decoder (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 instr_valid,
  input  wire logic [15:0]          instr_word,
  input  wire logic [15:0]          next_word,
  input  wire logic [3:0]           bank_select,
  input  wire logic [4:0]           status_flags,
  input  wire logic                 tested_bit,
  output logic                      dec_valid,
  output bcld_pkg::bcld_op_type     dec_op,
  output logic [11:0]               dec_file_addr,
  output logic [2:0]                dec_bit_pos,
  output logic [7:0]                dec_literal,
  output logic [10:0]               dec_offset,
  output logic [19:0]               dec_target,
  output logic                      dec_fast,
  output logic [1:0]                dec_ptr_index,
  output logic [11:0]               dec_literal12,
  output logic [1:0]                dec_tbl_mode,
  output logic [2:0]                dec_cond_sel,
  output logic [1:0]                dec_cycles,
  output logic [4:0]                dec_flag_mask,
  output logic                      dec_taken,
  output logic                      dec_use_pins,
  output logic                      dec_clr_presc,
  output logic                      dec_wdt_upd,
  output logic                      dec_int_upd
);
  import bcld_pkg::*;

  typedef struct packed {
    bcld_state_type state;
    logic [15:0]    first_word;
    logic           ctrl_enable;
    logic           ctrl_presc;
    logic [11:0]    timer_addr;
    logic [11:0]    port_lo;
    logic [11:0]    port_hi;
    logic [15:0]    count;
    logic [31:0]    prdata;
    logic           dec_valid;
    bcld_dec_type   dec;
  } bcld_regs_type;

  bcld_regs_type r_r;
  bcld_regs_type r_nxt;
  logic          accept;
  logic          mapped;
  bcld_dec_type  word_dec;

  // true when the word would be the head of a two-word pair, and for any 1100 word
  function automatic logic is_two_word(input logic [15:0] w);
    is_two_word = (w[15:9] == 7'b1110_110) || (w[15:9] == 7'b1110_111) ||
                  (w[15:12] == 4'hc);
  endfunction

  // single word decode; two-word heads are flagged and merged later
  function automatic bcld_dec_type decode_word(
    input logic [15:0] w, input logic [15:0] nw, input logic [3:0] bank_select_register,
    input logic [4:0] fl, input logic tb, input logic presc,
    input logic [11:0] tmr, input logic [11:0] plo, input logic [11:0] phi);
    bcld_dec_type d;
    logic         cond;
    d           = '0;
    d.op        = OP_NOP;
    d.cycles    = CYC_ONE;
    d.flag_mask = MASK_NONE;
    d.literal   = w[7:0];
    d.bit_pos   = w[11:9];
    d.offset    = w[10:0];
    d.cond_sel  = w[10:8];
    d.fast      = w[0];
    d.tbl_mode  = w[1:0];
    if (w[8]) begin
      d.file_addr = {bank_select_register, w[7:0]};
    end else if (w[7:0] < ACCESS_SPLIT) begin
      d.file_addr = {ACCESS_LOW, w[7:0]};
    end else begin
      d.file_addr = {ACCESS_HIGH, w[7:0]};
    end
    // branch condition: zero, carry, overflow, negative and inverses
    case (w[10:9])
      2'b00:   cond = fl[FLG_Z];
      2'b01:   cond = fl[FLG_C];
      2'b10:   cond = fl[FLG_OV];
      default: cond = fl[FLG_N];
    endcase
    cond = cond ^ w[8];
    // unlisted words fall through as nop
    casez (w)
      16'b1001_????_????_????: d.op = OP_CLEAR_ONE_BIT;
      16'b1000_????_????_????: d.op = OP_SET_ONE_BIT;
      16'b0111_????_????_????: d.op = OP_INVERT_ONE_BIT;
      16'b1011_????_????_????: begin
        d.op     = OP_SKIP_WHEN_BIT_LOW;
        d.taken  = ~tb;
      end
      16'b1010_????_????_????: begin
        d.op     = OP_SKIP_WHEN_BIT_HIGH;
        d.taken  = tb;
      end
      16'b1110_0???_????_????: begin
        d.op     = OP_BRANCH_COND;
        d.taken  = cond;
        d.cycles = cond ? CYC_TWO : CYC_ONE;
      end
      16'b1101_0???_????_????: begin
        d.op     = OP_JUMP_RELATIVE_ALWAYS;
        d.cycles = CYC_TWO;
        d.taken  = 1'b1;
      end
      16'b1101_1???_????_????: begin
        d.op     = OP_RELATIVE_SUBROUTINE_JUMP;
        d.cycles = CYC_TWO;
        d.taken  = 1'b1;
      end
      16'b1110_110?_????_????: begin
        d.op     = OP_ABSOLUTE_CALL;
        d.first  = 1'b1;
        d.fast   = w[8];
      end
      16'b1110_1111_????_????: begin
        d.op     = OP_ABSOLUTE_JUMP;
        d.first  = 1'b1;
      end
      16'b1110_1110_????_????: begin
        d.op        = OP_LOAD_POINTER_REGISTER;
        d.first     = 1'b1;
        d.ptr_index = w[5:4];
      end
      16'h0004: begin
        d.op      = OP_WATCHDOG_KICK;
        d.wdt_upd = 1'b1;
      end
      16'h0003: begin
        d.op      = OP_STANDBY;
        d.wdt_upd = 1'b1;
      end
      16'h0005: d.op = OP_PUSH;
      16'h0006: d.op = OP_POP;
      16'b0000_0000_0001_000?: begin
        d.op      = OP_INTERRUPT_RETURN;
        d.cycles  = CYC_TWO;
        d.int_upd = 1'b1;
        d.taken   = 1'b1;
      end
      16'b0000_0000_0001_001?: begin
        d.op     = OP_SUB_RETURN;
        d.cycles = CYC_TWO;
        d.taken  = 1'b1;
      end
      16'b0000_1100_????_????: begin
        d.op     = OP_RETURN_WITH_CONSTANT;
        d.cycles = CYC_TWO;
        d.taken  = 1'b1;
      end
      16'b0000_1111_????_????: begin
        d.op        = OP_ADD_CONSTANT;
        d.flag_mask = MASK_ARITH;
      end
      16'b0000_1000_????_????: begin
        d.op        = OP_SUBTRACT_FROM_CONSTANT;
        d.flag_mask = MASK_ARITH;
      end
      16'b0000_1011_????_????: begin
        d.op        = OP_AND_CONSTANT;
        d.flag_mask = MASK_LOGIC;
      end
      16'b0000_1001_????_????: begin
        d.op        = OP_OR_CONSTANT;
        d.flag_mask = MASK_LOGIC;
      end
      16'b0000_1010_????_????: begin
        d.op        = OP_XOR_CONSTANT;
        d.flag_mask = MASK_LOGIC;
      end
      16'b0000_1110_????_????: d.op = OP_LOAD_CONSTANT;
      16'b0000_1101_????_????: d.op = OP_MULTIPLY_CONSTANT;
      16'b0000_0001_0000_????: begin
        d.op      = OP_LOAD_BANK_NUMBER;
        d.literal = {4'h0, w[3:0]};
      end
      16'b0000_0000_0000_10??: begin
        d.op     = OP_PROGRAM_MEMORY_READ;
        d.cycles = CYC_TWO;
      end
      16'b0000_0000_0000_11??: begin
        d.op     = OP_PROGRAM_MEMORY_WRITE;
        d.cycles = CYC_TWO;
      end
      // zero word and stray second words
      default: d.op = OP_NOP;
    endcase
    // skip length depends on the skipped word
    if ((d.op == OP_SKIP_WHEN_BIT_LOW || d.op == OP_SKIP_WHEN_BIT_HIGH) && d.taken) begin
      d.cycles = is_two_word(nw) ? CYC_THREE : CYC_TWO;
    end
    // port targets read back from pins
    if (d.op == OP_CLEAR_ONE_BIT || d.op == OP_SET_ONE_BIT || d.op == OP_INVERT_ONE_BIT) begin
      d.use_pins  = (d.file_addr >= plo) && (d.file_addr <= phi);
      d.clr_presc = presc && (d.file_addr == tmr);
    end
    decode_word = d;
  endfunction

  assign accept   = instr_valid & r_r.ctrl_enable;
  assign word_dec = decode_word(instr_word, next_word, bank_select, status_flags, tested_bit,
                                r_r.ctrl_presc, r_r.timer_addr, r_r.port_lo, r_r.port_hi);
  assign mapped   = (paddr == REG_CTRL) || (paddr == REG_TIMER_ADDR) ||
                    (paddr == REG_PORT_LO) || (paddr == REG_PORT_HI) ||
                    (paddr == REG_STATUS) || (paddr == REG_COUNT);

  // next state: apb slave plus decode pipeline
  always_comb begin
    r_nxt           = r_r;
    r_nxt.dec_valid = 1'b0;
    // read data latched in setup so it stands through the access cycle
    if (psel && !penable && !pwrite) begin
      case (paddr)
        REG_CTRL:       r_nxt.prdata = {30'h0, r_r.ctrl_presc, r_r.ctrl_enable};
        REG_TIMER_ADDR: r_nxt.prdata = {20'h0, r_r.timer_addr};
        REG_PORT_LO:    r_nxt.prdata = {20'h0, r_r.port_lo};
        REG_PORT_HI:    r_nxt.prdata = {20'h0, r_r.port_hi};
        REG_STATUS:     r_nxt.prdata = {19'h0, (r_r.state == ST_WORD2), 2'h0,
                                        r_r.dec.cycles, 3'h0, r_r.dec.op};
        REG_COUNT:      r_nxt.prdata = {16'h0, r_r.count};
        default:        r_nxt.prdata = 32'h0;
      endcase
    end
    // writes land on the access edge; read-only offsets ignore them
    if (psel && penable && pwrite) begin
      case (paddr)
        REG_CTRL: begin
          r_nxt.ctrl_enable = pwdata[CTRL_ENABLE_BIT];
          r_nxt.ctrl_presc  = pwdata[CTRL_PRESC_BIT];
        end
        REG_TIMER_ADDR: r_nxt.timer_addr = pwdata[11:0];
        REG_PORT_LO:    r_nxt.port_lo    = pwdata[11:0];
        REG_PORT_HI:    r_nxt.port_hi    = pwdata[11:0];
        default:        r_nxt.count      = r_r.count;
      endcase
    end
    // decode and publish one result per instruction
    if (accept) begin
      case (r_r.state)
        ST_WORD1: begin
          if (word_dec.first) begin
            r_nxt.first_word = instr_word;
            r_nxt.dec        = word_dec;
            r_nxt.state      = ST_WORD2;
          end else begin
            r_nxt.dec       = word_dec;
            r_nxt.dec_valid = 1'b1;
            r_nxt.count     = r_r.count + 16'h0001;
          end
        end
        ST_WORD2: begin
          r_nxt.state     = ST_WORD1;
          r_nxt.dec_valid = 1'b1;
          r_nxt.count     = r_r.count + 16'h0001;
          if (instr_word[15:12] == 4'hf) begin
            r_nxt.dec.target    = {instr_word[11:0], r_r.first_word[7:0]};
            r_nxt.dec.literal12 = {r_r.first_word[3:0], instr_word[7:0]};
            r_nxt.dec.literal   = instr_word[7:0];
            r_nxt.dec.cycles    = CYC_TWO;
            r_nxt.dec.taken     = (r_r.dec.op != OP_LOAD_POINTER_REGISTER);
            r_nxt.dec.first     = 1'b0;
          end else begin
            // a broken pair drops its head and decodes the new word fresh
            r_nxt.dec = word_dec;
            if (word_dec.first) begin
              r_nxt.first_word = instr_word;
              r_nxt.state      = ST_WORD2;
              r_nxt.dec_valid  = 1'b0;
              r_nxt.count      = r_r.count;
            end
          end
        end
        default: r_nxt.state = ST_WORD1;
      endcase
    end
  end

  // registers; reset loads constants only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_r             <= '0;
      r_r.state       <= ST_WORD1;
      r_r.ctrl_enable <= CTRL_ENABLE_RST;
      r_r.ctrl_presc  <= CTRL_PRESC_RST;
      r_r.timer_addr  <= TIMER_ADDR_RST;
      r_r.port_lo     <= PORT_LO_RST;
      r_r.port_hi     <= PORT_HI_RST;
      r_r.dec.op      <= OP_NOP;
      r_r.dec.cycles  <= CYC_ONE;
    end else begin
      r_r <= r_nxt;
    end
  end

  // outputs straight from flip-flops except pready, tied high, and pslverr, which is combinational; zero-wait apb answer
  assign prdata        = r_r.prdata;
  assign pready        = 1'b1;
  assign pslverr       = psel & penable & ~mapped;
  assign dec_valid     = r_r.dec_valid;
  assign dec_op        = r_r.dec.op;
  assign dec_file_addr = r_r.dec.file_addr;
  assign dec_bit_pos   = r_r.dec.bit_pos;
  assign dec_literal   = r_r.dec.literal;
  assign dec_offset    = r_r.dec.offset;
  assign dec_target    = r_r.dec.target;
  assign dec_fast      = r_r.dec.fast;
  assign dec_ptr_index = r_r.dec.ptr_index;
  assign dec_literal12 = r_r.dec.literal12;
  assign dec_tbl_mode  = r_r.dec.tbl_mode;
  assign dec_cond_sel  = r_r.dec.cond_sel;
  assign dec_cycles    = r_r.dec.cycles;
  assign dec_flag_mask = r_r.dec.flag_mask;
  assign dec_taken     = r_r.dec.taken;
  assign dec_use_pins  = r_r.dec.use_pins;
  assign dec_clr_presc = r_r.dec.clr_presc;
  assign dec_wdt_upd   = r_r.dec.wdt_upd;
  assign dec_int_upd   = r_r.dec.int_upd;

  // checks on the decode results
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic fresh;
  assign fresh = accept && (r_r.state == ST_WORD1);

  sequence s_call_head;
    fresh && (instr_word[15:9] == 7'b1110_110);
  endsequence
  sequence s_second_word;
    instr_valid && (instr_word[15:12] == 4'hf);
  endsequence

  a_bit_modify_ones: assert property (fresh && instr_word[15:12] == 4'h9 |=>
    dec_valid && dec_op == OP_CLEAR_ONE_BIT && dec_cycles == 2'h1 && dec_flag_mask == 5'h00)
    else $error("bit clear decode wrong");
  a_skip_two_word: assert property (fresh && instr_word[15:12] == 4'hb && !tested_bit &&
    next_word[15:8] == 8'hef |=> dec_cycles == 2'h3 && dec_taken)
    else $error("skip over two-word not three cycles");
  a_branch_zero_taken: assert property (fresh && instr_word[15:8] == 8'he0 &&
    status_flags[2] |=> dec_taken && dec_cycles == 2'h2 && dec_offset[7:0] == $past(instr_word[7:0]))
    else $error("branch on zero not taken");
  a_rel_jump_offset: assert property (fresh && instr_word[15:11] == 5'b11010 |=>
    dec_op == OP_JUMP_RELATIVE_ALWAYS && dec_cycles == 2'h2 && dec_offset == $past(instr_word[10:0]))
    else $error("relative jump decode wrong");
  a_call_abs_target: assert property (s_call_head ##1 s_second_word |=>
    dec_valid && dec_op == OP_ABSOLUTE_CALL &&
    dec_target == {$past(instr_word[11:0]), $past(instr_word[7:0], 2)} &&
    dec_fast == $past(instr_word[8], 2))
    else $error("absolute call target wrong");
  a_jump_head_silent: assert property (fresh && instr_word[15:8] == 8'hef |=> !dec_valid)
    else $error("jump head produced a result");
  a_stray_second_nop: assert property (fresh && instr_word[15:12] == 4'hf |=>
    dec_valid && dec_op == OP_NOP && dec_cycles == 2'h1)
    else $error("stray second word not nop");
  a_watchdog_status: assert property (fresh && instr_word == 16'h0004 |=>
    dec_op == OP_WATCHDOG_KICK && dec_wdt_upd && dec_cycles == 2'h1)
    else $error("watchdog kick status not flagged");
  a_int_return_enable: assert property (fresh && instr_word[15:1] == 15'h0008 |=>
    dec_int_upd && dec_cycles == 2'h2 && dec_fast == $past(instr_word[0]))
    else $error("interrupt return decode wrong");
  a_literal_flag_mask: assert property (fresh && instr_word[15:8] == 8'h0b |=>
    dec_flag_mask == 5'h14 && dec_literal == $past(instr_word[7:0]))
    else $error("and constant mask wrong");
  a_access_bank_low: assert property (fresh && instr_word[15:12] == 4'h8 &&
    !instr_word[8] && instr_word[7:0] < 8'h60 |=> dec_file_addr[11:8] == 4'h0)
    else $error("access bank not forced");
  a_presc_clear_timer: assert property (fresh && instr_word[15:12] == 4'h8 &&
    r_r.ctrl_presc && !instr_word[8] && instr_word[7:0] < 8'h60 &&
    {4'h0, instr_word[7:0]} == r_r.timer_addr
    |=> dec_clr_presc)
    else $error("prescaler clear missed");

endmodule // bcld_decoder

// ---- core/bcld_pkg.sv ----
// Purpose: constants and types for the bit, control and literal decoder
// Assumes: 16-bit instruction words, 8-bit file addresses widened to 12 bits
// Notes:   register offsets are byte addresses on a 32-bit apb bus
package bcld_pkg;

  // apb register map
  localparam logic [7:0]  REG_CTRL       = 8'h00;
  localparam logic [7:0]  REG_TIMER_ADDR = 8'h04;
  localparam logic [7:0]  REG_PORT_LO    = 8'h08;
  localparam logic [7:0]  REG_PORT_HI    = 8'h0c;
  localparam logic [7:0]  REG_STATUS     = 8'h10;
  localparam logic [7:0]  REG_COUNT      = 8'h14;

  // control field positions and reset values
  localparam int          CTRL_ENABLE_BIT = 0;
  localparam int          CTRL_PRESC_BIT  = 1;
  localparam logic        CTRL_ENABLE_RST = 1'b1;
  localparam logic        CTRL_PRESC_RST  = 1'b0;
  localparam logic [11:0] TIMER_ADDR_RST  = 12'h000;
  localparam logic [11:0] PORT_LO_RST     = 12'hfff;
  localparam logic [11:0] PORT_HI_RST     = 12'h000;
  localparam int          STATUS_CYC_POS  = 8;
  localparam int          STATUS_PEND_POS = 12;

  // status flag and update mask positions
  localparam int          FLG_C  = 0;
  localparam int          FLG_DC = 1;
  localparam int          FLG_Z  = 2;
  localparam int          FLG_OV = 3;
  localparam int          FLG_N  = 4;
  localparam logic [4:0]  MASK_NONE  = 5'h00;
  localparam logic [4:0]  MASK_ARITH = 5'h1f;
  localparam logic [4:0]  MASK_LOGIC = 5'h14;

  // access bank split and bank numbers
  localparam logic [7:0]  ACCESS_SPLIT = 8'h60;
  localparam logic [3:0]  ACCESS_LOW   = 4'h0;
  localparam logic [3:0]  ACCESS_HIGH  = 4'hf;

  // cycle counts
  localparam logic [1:0]  CYC_ONE   = 2'h1;
  localparam logic [1:0]  CYC_TWO   = 2'h2;
  localparam logic [1:0]  CYC_THREE = 2'h3;

  typedef enum logic [1:0] {
    ST_WORD1 = 2'b01,
    ST_WORD2 = 2'b10
  } bcld_state_type;

  typedef enum logic [4:0] {
    OP_NOP, OP_CLEAR_ONE_BIT, OP_SET_ONE_BIT, OP_INVERT_ONE_BIT,
    OP_SKIP_WHEN_BIT_LOW, OP_SKIP_WHEN_BIT_HIGH, OP_BRANCH_COND,
    OP_JUMP_RELATIVE_ALWAYS, OP_RELATIVE_SUBROUTINE_JUMP, OP_ABSOLUTE_CALL,
    OP_ABSOLUTE_JUMP, OP_WATCHDOG_KICK, OP_STANDBY, OP_PUSH, OP_POP,
    OP_INTERRUPT_RETURN, OP_SUB_RETURN, OP_RETURN_WITH_CONSTANT,
    OP_ADD_CONSTANT, OP_SUBTRACT_FROM_CONSTANT, OP_AND_CONSTANT,
    OP_OR_CONSTANT, OP_XOR_CONSTANT, OP_LOAD_CONSTANT, OP_MULTIPLY_CONSTANT,
    OP_LOAD_BANK_NUMBER, OP_LOAD_POINTER_REGISTER, OP_PROGRAM_MEMORY_READ,
    OP_PROGRAM_MEMORY_WRITE
  } bcld_op_type;

  // one decoded instruction
  typedef struct packed {
    logic        first;       // first word of a two-word pair
    bcld_op_type op;
    logic [11:0] file_addr;
    logic [2:0]  bit_pos;
    logic [7:0]  literal;
    logic [10:0] offset;
    logic [19:0] target;
    logic        fast;
    logic [1:0]  ptr_index;
    logic [11:0] literal12;
    logic [1:0]  tbl_mode;
    logic [2:0]  cond_sel;
    logic [1:0]  cycles;
    logic [4:0]  flag_mask;
    logic        taken;
    logic        use_pins;
    logic        clr_presc;
    logic        wdt_upd;
    logic        int_upd;
  } bcld_dec_type;

endpackage

// ---- test/bcld_decoder_tb_top.sv ----
// Purpose: self-checking bench for the instruction decoder
// Assumes: zero-wait apb, one result per word or word pair
// Notes:   expected values come from the encodings, not the design
`timescale 1ns/1ps
module bcld_decoder_tb_top;
  import bcld_pkg::*;
  logic pclk = 1'b0, presetn, psel, penable, pwrite, pready, pslverr, er_v;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic load, instr_valid, tested_bit, found;
  logic [15:0] word, follow, instr_word, next_word;
  logic [3:0]  bank_select;
  logic [4:0]  status_flags;
  int n_fail = 0, cmp_count = 0, cyc = 0;
  bcld_op_type dec_op;
  logic dec_valid, dec_fast, dec_taken, dec_use_pins, dec_clr_presc, dec_wdt_upd, dec_int_upd;
  logic [11:0] dec_file_addr, dec_literal12;
  logic [2:0]  dec_bit_pos, dec_cond_sel;
  logic [7:0]  dec_literal;
  logic [10:0] dec_offset;
  logic [19:0] dec_target;
  logic [1:0]  dec_ptr_index, dec_tbl_mode, dec_cycles;
  logic [4:0]  dec_flag_mask;
  always #5 pclk = ~pclk;
  bcld_fetch_model fetch (.pclk(pclk), .presetn(presetn), .load(load), .word(word),
    .follow(follow), .instr_valid(instr_valid), .instr_word(instr_word), .next_word(next_word));
  bcld_decoder dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .instr_valid(instr_valid), .instr_word(instr_word),
    .next_word(next_word), .bank_select(bank_select), .status_flags(status_flags),
    .tested_bit(tested_bit), .dec_valid(dec_valid), .dec_op(dec_op),
    .dec_file_addr(dec_file_addr), .dec_bit_pos(dec_bit_pos), .dec_literal(dec_literal),
    .dec_offset(dec_offset), .dec_target(dec_target), .dec_fast(dec_fast),
    .dec_ptr_index(dec_ptr_index), .dec_literal12(dec_literal12),
    .dec_tbl_mode(dec_tbl_mode), .dec_cond_sel(dec_cond_sel), .dec_cycles(dec_cycles),
    .dec_flag_mask(dec_flag_mask), .dec_taken(dec_taken), .dec_use_pins(dec_use_pins),
    .dec_clr_presc(dec_clr_presc), .dec_wdt_upd(dec_wdt_upd), .dec_int_upd(dec_int_upd));
  task complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // a hang is cut short well past the expected run length
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_fail++;
      complete_run();
    end
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask
  // setup, then access held until pready is seen high at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // pready seen high ends this wait; the bench timeout catches a hang
    do @(posedge pclk); while (pready !== 1'b1);
    rd_v = prdata; er_v = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task issue(input logic [15:0] w, input logic [15:0] nw);
    @(posedge pclk);
    load <= 1'b1; word <= w; follow <= nw;
  endtask
  // waits a bounded time for a result pulse
  task expect_out(input logic want);
    @(posedge pclk);
    load <= 1'b0;
    found = 1'b0;
    repeat (5) if (!found) begin @(posedge pclk); #1; found = (dec_valid === 1'b1); end
    chk("valid", {31'h0, want}, {31'h0, found});
  endtask
  task dec(input logic [15:0] w, nw, input bcld_op_type op, input logic [1:0] c, input logic [4:0] m);
    issue(w, nw);
    expect_out(1'b1);
    chk("op", {27'h0, op}, {27'h0, dec_op});
    chk("cycles", {30'h0, c}, {30'h0, dec_cycles});
    chk("mask", {27'h0, m}, {27'h0, dec_flag_mask});
  endtask
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    load = 1'b0; word = 16'h0000; follow = 16'h0000; tested_bit = 1'b0;
    bank_select = 4'h5; status_flags = 5'h05;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, REG_CTRL, 32'h0); chk("ctrl", 32'h1, rd_v);
    apb(1'b0, REG_PORT_LO, 32'h0); chk("port_lo", 32'hfff, rd_v);
    apb(1'b0, 8'h40, 32'h0); chk("slverr", 32'h1, {31'h0, er_v});
    apb(1'b1, REG_CTRL, 32'h3); apb(1'b1, REG_TIMER_ADDR, 32'h00a);
    apb(1'b1, REG_PORT_LO, 32'hf80); apb(1'b1, REG_PORT_HI, 32'hf8f);
    dec(16'h800a, 16'h0, OP_SET_ONE_BIT, CYC_ONE, MASK_NONE);
    chk("presc", 32'h1, {31'h0, dec_clr_presc});
    chk("faddr", 32'h00a, {20'h0, dec_file_addr});
    dec(16'h9080, 16'h0, OP_CLEAR_ONE_BIT, CYC_ONE, MASK_NONE);
    chk("pins", 32'h1, {31'h0, dec_use_pins});
    chk("faddr", 32'hf80, {20'h0, dec_file_addr});
    dec(16'h7b0a, 16'h0, OP_INVERT_ONE_BIT, CYC_ONE, MASK_NONE);
    chk("bank", 32'h50a, {20'h0, dec_file_addr});
    chk("bit", 32'h5, {29'h0, dec_bit_pos});
    dec(16'hb000, 16'h0f00, OP_SKIP_WHEN_BIT_LOW, CYC_TWO, MASK_NONE);
    dec(16'hb000, 16'hef00, OP_SKIP_WHEN_BIT_LOW, CYC_THREE, MASK_NONE);
    tested_bit = 1'b1;
    dec(16'hb000, 16'hef00, OP_SKIP_WHEN_BIT_LOW, CYC_ONE, MASK_NONE);
    dec(16'ha000, 16'hc000, OP_SKIP_WHEN_BIT_HIGH, CYC_THREE, MASK_NONE);
    // flags hold carry and zero; odd codes test the inverse
    for (int c = 0; c < 8; c++) begin
      automatic int ix = (c / 2 == 0) ? FLG_Z : (c / 2 == 1) ? FLG_C : (c / 2 == 2) ? FLG_OV : FLG_N;
      automatic logic t = status_flags[ix] ^ c[0];
      dec({5'b11100, c[2:0], 8'h10}, 16'h0, OP_BRANCH_COND, t ? CYC_TWO : CYC_ONE, MASK_NONE);
      chk("taken", {31'h0, t}, {31'h0, dec_taken});
      chk("cond", c, {29'h0, dec_cond_sel});
    end
    dec(16'hd7ff, 16'h0, OP_JUMP_RELATIVE_ALWAYS, CYC_TWO, MASK_NONE);
    chk("offset", 32'h7ff, {21'h0, dec_offset});
    dec(16'hd801, 16'h0, OP_RELATIVE_SUBROUTINE_JUMP, CYC_TWO, MASK_NONE);
    issue(16'hed12, 16'h0); dec(16'hf345, 16'h0, OP_ABSOLUTE_CALL, CYC_TWO, MASK_NONE);
    chk("target", 32'h34512, {12'h0, dec_target});
    chk("fast", 32'h1, {31'h0, dec_fast});
    issue(16'hef00, 16'h0); dec(16'hf123, 16'h0, OP_ABSOLUTE_JUMP, CYC_TWO, MASK_NONE);
    chk("target", 32'h12300, {12'h0, dec_target});
    issue(16'hee1a, 16'h0); dec(16'hf0bc, 16'h0, OP_LOAD_POINTER_REGISTER, CYC_TWO, MASK_NONE);
    chk("lit12", 32'habc, {20'h0, dec_literal12});
    chk("ptr", 32'h1, {30'h0, dec_ptr_index});
    dec(16'hf123, 16'h0, OP_NOP, CYC_ONE, MASK_NONE);
    dec(16'h0000, 16'h0, OP_NOP, CYC_ONE, MASK_NONE);
    dec(16'h0007, 16'h0, OP_NOP, CYC_ONE, MASK_NONE);
    dec(16'h0004, 16'h0, OP_WATCHDOG_KICK, CYC_ONE, MASK_NONE);
    chk("wdt", 32'h1, {31'h0, dec_wdt_upd});
    dec(16'h0003, 16'h0, OP_STANDBY, CYC_ONE, MASK_NONE);
    dec(16'h0005, 16'h0, OP_PUSH, CYC_ONE, MASK_NONE);
    dec(16'h0006, 16'h0, OP_POP, CYC_ONE, MASK_NONE);
    dec(16'h0011, 16'h0, OP_INTERRUPT_RETURN, CYC_TWO, MASK_NONE);
    chk("intupd", 32'h1, {31'h0, dec_int_upd});
    dec(16'h0012, 16'h0, OP_SUB_RETURN, CYC_TWO, MASK_NONE);
    chk("fast", 32'h0, {31'h0, dec_fast});
    dec(16'h0c7f, 16'h0, OP_RETURN_WITH_CONSTANT, CYC_TWO, MASK_NONE);
    chk("literal", 32'h7f, {24'h0, dec_literal});
    dec(16'h0f01, 16'h0, OP_ADD_CONSTANT, CYC_ONE, MASK_ARITH);
    dec(16'h0801, 16'h0, OP_SUBTRACT_FROM_CONSTANT, CYC_ONE, MASK_ARITH);
    dec(16'h0b01, 16'h0, OP_AND_CONSTANT, CYC_ONE, MASK_LOGIC);
    dec(16'h0901, 16'h0, OP_OR_CONSTANT, CYC_ONE, MASK_LOGIC);
    dec(16'h0a01, 16'h0, OP_XOR_CONSTANT, CYC_ONE, MASK_LOGIC);
    dec(16'h0d01, 16'h0, OP_MULTIPLY_CONSTANT, CYC_ONE, MASK_NONE);
    issue(16'hef00, 16'h0); dec(16'h0e55, 16'h0, OP_LOAD_CONSTANT, CYC_ONE, MASK_NONE);
    dec(16'h0107, 16'h0, OP_LOAD_BANK_NUMBER, CYC_ONE, MASK_NONE);
    for (int m = 0; m < 4; m++) begin
      dec(16'h0008 | m, 16'h0, OP_PROGRAM_MEMORY_READ, CYC_TWO, MASK_NONE);
      chk("mode", m, {30'h0, dec_tbl_mode});
      dec(16'h000c | m, 16'h0, OP_PROGRAM_MEMORY_WRITE, CYC_TWO, MASK_NONE);
      chk("mode", m, {30'h0, dec_tbl_mode});
    end
    apb(1'b1, REG_CTRL, 32'h0);
    issue(16'h0e01, 16'h0); expect_out(1'b0);
    complete_run();
  end
endmodule // bcld_decoder_tb_top

// ---- test/bcld_fetch_model.sv ----
// Purpose: fetch unit and program memory stand-in
// Assumes: bench asks for one word per cycle with load
// Notes:   idle word lines toggle each cycle, starting from the inverse of the last word
`timescale 1ns/1ps
module bcld_fetch_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        load,
  input  wire logic [15:0] word,
  input  wire logic [15:0] follow,
  output logic             instr_valid,
  output logic [15:0]      instr_word,
  output logic [15:0]      next_word
);
  // one registered word per request; idle lines toggle so stale words never pass
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_valid <= 1'b0;
      instr_word  <= 16'h0000;
      next_word   <= 16'h0000;
    end else begin
      instr_valid <= load;
      instr_word  <= load ? word : ~instr_word;
      next_word   <= load ? follow : ~next_word;
    end
  end
endmodule // bcld_fetch_model
